// >>> design/bpg_pad_ctrl.v
// Bidirectional pad control cell with receiver and termination gating behind an APB slave.
//
// Operation
// R1 - Driver is high impedance while tristate control is high, drives when low.
// R2 - Basic variants keep receiver and termination on while tristated.
// R3 - Basic variants switch termination off while driving.
// R4 - Receiver-off request while tristated powers receiver down, received value low.
// R5 - Termination-off request while tristated disconnects termination legs.
// R6 - Calibrated variant: receiver and termination follow their requests independently.
// R7 - Disable-capable variants: driving turns receiver and termination off, value low.
// R8 - Fabric enables gating and drives receiver-off, or leaves gating unused.
// R9 - Uncalibrated variant gates only uncalibrated legs with its request.
// R10 - Uncalibrated variant: receiver and termination follow their own requests.
// R11 - Offset-trimmed variant offers trim enable and four-bit trim code.
// R12 - Reference scanning only with a reference control cell present.
// R13 - Complementary variants give true and inverted received values.
// R14 - Fabric drives master and slave tristate from one common signal.
// R15 - Complementary term-gated variant: termination by request only, receiver stays on.
// R16 - Complementary variants ignore the receiver-off request.
// R17 - Enabled receiver passes sensed level unchanged to the received output.
//
// Our own choices: the APB slave port and the placing of the registers.
`timescale 1ns/10ps
`include "bpg_regs.vh"
module bpg_pad_ctrl (
    input wire I_CLOCK,
    input wire I_RST_N,
    input wire I_PSEL,
    input wire I_PENABLE,
    input wire I_PWRITE,
    input wire [7:0] I_PADDR,
    input wire [31:0] I_PWDATA,
    output wire [31:0] O_PRDATA,
    output wire O_PREADY,
    output wire O_PSLVERR,
    input wire I_PAD_P_I,
    output wire O_PAD_P_O,
    output wire O_PAD_P_OE,
    input wire I_PAD_N_I,
    output wire O_PAD_N_O,
    output wire O_PAD_N_OE,
    input wire I_REF_CELL_PRESENT,
    output wire O_RECEIVED,
    output wire O_RECEIVED_INVERTED,
    output wire O_RX_EN,
    output wire O_CAL_TERM_EN,
    output wire O_UNCAL_TERM_EN,
    output wire O_OFFSET_TRIM_ENABLE,
    output wire [3:0] O_OFFSET_TRIM_CODE,
    output wire O_VREF_SCAN_EN
);

    // ------------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------------
    reg [`BPG_CTRL_W-1:0] ctrl_q;
    reg [`BPG_TRIM_W-1:0] trim_q;
    reg [31:0] prdata_q;
    reg rx_en_q;
    reg cal_term_q;
    reg uncal_term_q;
    reg received_q;
    reg received_inv_q;
    reg trim_en_q;
    reg [3:0] trim_code_q;
    reg vref_scan_q;

    // ------------------------------------------------------------------------
    // Variant decode
    // ------------------------------------------------------------------------
    wire [2:0] variant;
    wire is_diff;
    wire is_compl;
    wire master_hiz;
    wire slave_hiz;
    wire drive_data;

    assign variant = ctrl_q[`BPG_CTRL_VARIANT_MSB:`BPG_CTRL_VARIANT_LSB];
    assign is_diff = variant[2];
    assign is_compl = (variant == `BPG_VAR_DIFF_BIDIR_COMPLEMENTARY) ||
                      (variant == `BPG_VAR_DIFF_BIDIR_COMPL_TERM_GATED);
    assign drive_data = ctrl_q[`BPG_CTRL_DRIVE_DATA];
    assign master_hiz = ctrl_q[`BPG_CTRL_MASTER_HIZ];
    // Outside the complementary variants there is one tristate control.
    assign slave_hiz = is_compl ? ctrl_q[`BPG_CTRL_SLAVE_HIZ] : master_hiz;

    // ------------------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------------------
    wire setup_phase;
    wire access_phase;
    wire hit_ctrl;
    wire hit_trim;
    wire hit_status;
    wire addr_hit;
    wire wr_ctrl;
    wire wr_trim;

    assign setup_phase = I_PSEL & ~I_PENABLE;
    assign access_phase = I_PSEL & I_PENABLE;
    assign hit_ctrl = (I_PADDR == `BPG_OFS_CTRL);
    assign hit_trim = (I_PADDR == `BPG_OFS_TRIM);
    assign hit_status = (I_PADDR == `BPG_OFS_STATUS);
    assign addr_hit = hit_ctrl | hit_trim | hit_status;
    // The status word is read-only: a write to it is dropped without an error.
    assign wr_ctrl = access_phase & I_PWRITE & hit_ctrl;
    assign wr_trim = access_phase & I_PWRITE & hit_trim;

    // Zero wait states: read data is prepared in the setup cycle.
    // A master that skipped the setup cycle would therefore read stale data.
    assign O_PREADY = 1'b1;
    assign O_PSLVERR = access_phase & ~addr_hit;
    assign O_PRDATA = prdata_q;

    // ------------------------------------------------------------------------
    // Status word
    // ------------------------------------------------------------------------
    // The driving bit is live from the control register; all others are the
    // registered outputs, so software reads exactly what the fabric pins show.
    wire [`BPG_STAT_W-1:0] status_word;
    assign status_word = {
        vref_scan_q,
        ~master_hiz,
        received_inv_q,
        received_q,
        uncal_term_q,
        cal_term_q,
        rx_en_q
    };

    reg [31:0] rd_mux;
    always @*
    begin
        rd_mux = 32'h00000000;
        case (I_PADDR)
            `BPG_OFS_CTRL:
            begin
                rd_mux = {22'h000000, ctrl_q};
            end
            `BPG_OFS_TRIM:
            begin
                rd_mux = {23'h000000, trim_q};
            end
            `BPG_OFS_STATUS:
            begin
                rd_mux = {25'h0000000, status_word};
            end
            default:
            begin
                rd_mux = 32'h00000000;
            end
        endcase
    end

    reg [`BPG_CTRL_W-1:0] ctrl_d;
    reg [`BPG_TRIM_W-1:0] trim_d;
    reg [31:0] prdata_d;

    // A write lands only at the access edge, so a setup cycle alone never disturbs a register.
    // Bits above a register's width are dropped and read back as zero.
    always @*
    begin
        ctrl_d = ctrl_q;
        trim_d = trim_q;
        prdata_d = prdata_q;
        if (wr_ctrl)
        begin
            ctrl_d = I_PWDATA[`BPG_CTRL_W-1:0];
        end
        if (wr_trim)
        begin
            trim_d = I_PWDATA[`BPG_TRIM_W-1:0];
        end
        // Read data is captured at setup so that it stands through the whole access phase.
        if (setup_phase & ~I_PWRITE)
        begin
            prdata_d = rd_mux;
        end
    end

    always @(posedge I_CLOCK or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            ctrl_q <= `BPG_CTRL_RESET;
            trim_q <= `BPG_TRIM_RESET;
            prdata_q <= `BPG_PRDATA_RESET;
        end
        else
        begin
            ctrl_q <= ctrl_d;
            trim_q <= trim_d;
            prdata_q <= prdata_d;
        end
    end

    // ------------------------------------------------------------------------
    // Pad drivers
    // ------------------------------------------------------------------------
    // Output enable high means the pin is driven.
    // The data pins follow the register even while released; the board ignores them then.
    assign O_PAD_P_O = drive_data;
    assign O_PAD_P_OE = ~master_hiz; // R1
    assign O_PAD_N_O = ~drive_data;
    // The N pin is only a driver in the differential variants.
    assign O_PAD_N_OE = is_diff & ~slave_hiz; // R1 R14

    // ------------------------------------------------------------------------
    // Pad sensing
    // ------------------------------------------------------------------------
    wire pad_p_s;
    wire pad_n_s;
    wire ref_cell_s;

    // Every pin has its own two flip-flops; the three are independent levels, so no word
    // crosses here. Pad to received output therefore takes three rising edges.
    bpg_sync2 #(
        .W(1)
    ) u_sync_pad_p (
        .i_clk(I_CLOCK),
        .i_rst_n(I_RST_N),
        .i_async(I_PAD_P_I),
        .o_sync(pad_p_s)
    );

    bpg_sync2 #(
        .W(1)
    ) u_sync_pad_n (
        .i_clk(I_CLOCK),
        .i_rst_n(I_RST_N),
        .i_async(I_PAD_N_I),
        .o_sync(pad_n_s)
    );

    bpg_sync2 #(
        .W(1)
    ) u_sync_ref_cell (
        .i_clk(I_CLOCK),
        .i_rst_n(I_RST_N),
        .i_async(I_REF_CELL_PRESENT),
        .o_sync(ref_cell_s)
    );

    // A differential receiver resolves the pair by which leg is the higher.
    // Two equal legs read as low, so a briefly skewed pair reads low, not high.
    wire sensed;
    assign sensed = is_diff ? (pad_p_s & ~pad_n_s) : pad_p_s;

    // ------------------------------------------------------------------------
    // Receiver and termination gating
    // ------------------------------------------------------------------------
    wire rx_en_d;
    wire cal_term_d;
    wire uncal_term_d;
    wire force_low;

    // Gating follows the master half, which fabric ties to the slave half.
    // A split pair would leave the receiver gated by the P half alone.
    bpg_rx_gate u_gate (
        .i_variant(variant),
        .i_receiver_gating_used(ctrl_q[`BPG_CTRL_GATING_USED]),
        .i_hiz(master_hiz),
        .i_receiver_off_req(ctrl_q[`BPG_CTRL_RX_OFF]),
        .i_all_termination_off_req(ctrl_q[`BPG_CTRL_ALL_TERM_OFF]),
        .i_uncal_termination_off_req(ctrl_q[`BPG_CTRL_UNCAL_TERM_OFF]),
        .o_rx_en(rx_en_d),
        .o_cal_term_en(cal_term_d),
        .o_uncal_term_en(uncal_term_d),
        .o_force_low(force_low)
    );

    // ------------------------------------------------------------------------
    // Received value
    // ------------------------------------------------------------------------
    // No storage sits between the sync output and the received flop, so the
    // fabric sees the pad level itself, never a held copy.
    wire received_d;
    wire received_inv_d;
    assign received_d = (rx_en_d & ~force_low) ? sensed : 1'b0; // R17 R4 R7
    // The inverted leg is low too while the receiver is off.
    assign received_inv_d = (is_compl & rx_en_d & ~force_low) ? ~sensed : 1'b0; // R13

    // ------------------------------------------------------------------------
    // Offset trim and reference scan
    // ------------------------------------------------------------------------
    wire trimmed;
    assign trimmed = (variant == `BPG_VAR_BIDIR_OFFSET_TRIMMED);

    // Without a reference control cell a scan request is simply ignored.
    wire vref_scan_d;
    assign vref_scan_d = trimmed & trim_q[`BPG_TRIM_VREF_SCAN] & ref_cell_s; // R12

    wire trim_en_d;
    wire [3:0] trim_code_d;
    // Outside the trimmed variant the trim pins rest at zero so an idle receiver is not skewed.
    assign trim_en_d = trimmed & trim_q[`BPG_TRIM_ENABLE]; // R11
    assign trim_code_d = trimmed ? trim_q[`BPG_TRIM_CODE_MSB:`BPG_TRIM_CODE_LSB] : 4'h0; // R11

    always @(posedge I_CLOCK or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            trim_en_q <= `BPG_TRIM_EN_RESET;
            trim_code_q <= `BPG_TRIM_CODE_RESET;
            vref_scan_q <= `BPG_VREF_SCAN_RESET;
        end
        else
        begin
            trim_en_q <= trim_en_d; // R11
            trim_code_q <= trim_code_d; // R11
            vref_scan_q <= vref_scan_d; // R12
        end
    end

    // ------------------------------------------------------------------------
    // Gating and received-value registers
    // ------------------------------------------------------------------------
    // One flop on each fabric output keeps glitches of the gating decode off the pins.
    always @(posedge I_CLOCK or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            rx_en_q <= `BPG_RX_EN_RESET;
            cal_term_q <= `BPG_TERM_RESET;
            uncal_term_q <= `BPG_TERM_RESET;
            received_q <= `BPG_RECEIVED_RESET;
            received_inv_q <= `BPG_RECEIVED_RESET;
        end
        else
        begin
            rx_en_q <= rx_en_d; // R2 R4 R6 R7
            cal_term_q <= cal_term_d; // R3 R5
            uncal_term_q <= uncal_term_d; // R9 R10
            received_q <= received_d; // R17
            received_inv_q <= received_inv_d; // R13
        end
    end

    // ------------------------------------------------------------------------
    // Fabric-side outputs
    // ------------------------------------------------------------------------
    assign O_RECEIVED = received_q;
    assign O_RECEIVED_INVERTED = received_inv_q;
    assign O_RX_EN = rx_en_q;
    assign O_CAL_TERM_EN = cal_term_q;
    assign O_UNCAL_TERM_EN = uncal_term_q;
    assign O_OFFSET_TRIM_ENABLE = trim_en_q;
    assign O_OFFSET_TRIM_CODE = trim_code_q;
    assign O_VREF_SCAN_EN = vref_scan_q;

endmodule

// >>> design/bpg_regs.vh
// Register map, field positions, reset values and variant codes of the pad gating block.
`ifndef BPG_REGS_VH
`define BPG_REGS_VH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define BPG_ADDR_W 8
`define BPG_OFS_CTRL 8'h00
`define BPG_OFS_TRIM 8'h04
`define BPG_OFS_STATUS 8'h08

// ----------------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------------
`define BPG_CTRL_VARIANT_LSB 0
`define BPG_CTRL_VARIANT_MSB 2
`define BPG_CTRL_GATING_USED 3
`define BPG_CTRL_DRIVE_DATA 4
`define BPG_CTRL_MASTER_HIZ 5
`define BPG_CTRL_SLAVE_HIZ 6
`define BPG_CTRL_RX_OFF 7
`define BPG_CTRL_ALL_TERM_OFF 8
`define BPG_CTRL_UNCAL_TERM_OFF 9
`define BPG_CTRL_W 10
`define BPG_CTRL_RESET 10'h068

// ----------------------------------------------------------------------------
// Trim register fields
// ----------------------------------------------------------------------------
`define BPG_TRIM_ENABLE 0
`define BPG_TRIM_CODE_LSB 4
`define BPG_TRIM_CODE_MSB 7
`define BPG_TRIM_VREF_SCAN 8
`define BPG_TRIM_W 9
`define BPG_TRIM_RESET 9'h000

// ----------------------------------------------------------------------------
// Reset values of the registered outputs
// ----------------------------------------------------------------------------
`define BPG_PRDATA_RESET 32'h00000000
`define BPG_RX_EN_RESET 1'h1
`define BPG_TERM_RESET 1'h1
`define BPG_RECEIVED_RESET 1'h0
`define BPG_TRIM_EN_RESET 1'h0
`define BPG_TRIM_CODE_RESET 4'h0
`define BPG_VREF_SCAN_RESET 1'h0

// ----------------------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------------------
`define BPG_STAT_RX_EN 0
`define BPG_STAT_CAL_TERM 1
`define BPG_STAT_UNCAL_TERM 2
`define BPG_STAT_RECEIVED 3
`define BPG_STAT_RECEIVED_INV 4
`define BPG_STAT_DRIVING 5
`define BPG_STAT_VREF_SCAN 6
`define BPG_STAT_W 7

// ----------------------------------------------------------------------------
// Pad variants
// ----------------------------------------------------------------------------
`define BPG_VAR_BIDIR_BASIC 3'h0
`define BPG_VAR_BIDIR_CAL_TERM_GATED 3'h1
`define BPG_VAR_BIDIR_UNCAL_TERM_GATED 3'h2
`define BPG_VAR_BIDIR_OFFSET_TRIMMED 3'h3
`define BPG_VAR_DIFF_BIDIR_BASIC 3'h4
`define BPG_VAR_DIFF_BIDIR_CAL_TERM_GATED 3'h5
`define BPG_VAR_DIFF_BIDIR_COMPLEMENTARY 3'h6
`define BPG_VAR_DIFF_BIDIR_COMPL_TERM_GATED 3'h7

`endif

// >>> design/bpg_rx_gate.v
// Receiver and termination gating decision for each pad variant.
`timescale 1ns/10ps
`include "bpg_regs.vh"
module bpg_rx_gate (
    input wire [2:0] i_variant,
    input wire i_receiver_gating_used,
    input wire i_hiz,
    input wire i_receiver_off_req,
    input wire i_all_termination_off_req,
    input wire i_uncal_termination_off_req,
    output reg o_rx_en,
    output reg o_cal_term_en,
    output reg o_uncal_term_en,
    output reg o_force_low
);

    // With gating unused the receiver stays on even while driving.
    wire gated_rx_en;
    assign gated_rx_en = i_receiver_gating_used ? (i_hiz & ~i_receiver_off_req) : 1'b1;

    always @*
    begin
        o_rx_en = 1'b1;
        o_cal_term_en = i_hiz;
        o_uncal_term_en = i_hiz;
        o_force_low = 1'b0;
        case (i_variant)
            `BPG_VAR_BIDIR_CAL_TERM_GATED,
            `BPG_VAR_BIDIR_OFFSET_TRIMMED,
            `BPG_VAR_DIFF_BIDIR_CAL_TERM_GATED:
            begin
                o_rx_en = gated_rx_en; // R4 R6 R7 R8
                o_cal_term_en = i_hiz & ~i_all_termination_off_req; // R5 R6 R7
                o_uncal_term_en = i_hiz & ~i_all_termination_off_req; // R5 R6
                o_force_low = ~gated_rx_en; // R4 R7
            end
            `BPG_VAR_BIDIR_UNCAL_TERM_GATED:
            begin
                o_rx_en = gated_rx_en; // R10 R7
                o_uncal_term_en = i_hiz & ~i_uncal_termination_off_req; // R9 R10
                o_force_low = ~gated_rx_en; // R4 R7
            end
            `BPG_VAR_DIFF_BIDIR_COMPL_TERM_GATED:
            begin
                // The receiver-off request has no path into this variant.
                o_rx_en = i_hiz; // R15 R16 R7
                o_cal_term_en = i_hiz & ~i_all_termination_off_req; // R15
                o_uncal_term_en = i_hiz & ~i_all_termination_off_req; // R15
                o_force_low = ~i_hiz; // R7
            end
            default:
            begin
                o_rx_en = 1'b1; // R2 R16
                o_cal_term_en = i_hiz; // R2 R3
                o_uncal_term_en = i_hiz; // R2 R3
                o_force_low = 1'b0;
            end
        endcase
    end

endmodule

// >>> design/bpg_sync2.v
// Two-stage synchroniser for levels arriving from outside the clock domain.
`timescale 1ns/10ps
module bpg_sync2 #(
    parameter W = 1
) (
    input wire i_clk,
    input wire i_rst_n,
    input wire [W-1:0] i_async,
    output wire [W-1:0] o_sync
);

    reg [W-1:0] meta_q;
    reg [W-1:0] sync_q;

    always @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            meta_q <= {W{1'b0}};
            sync_q <= {W{1'b0}};
        end
        else
        begin
            meta_q <= i_async;
            sync_q <= meta_q;
        end
    end

    assign o_sync = sync_q;

endmodule

// >>> dv/bpg_pad_board.sv
// Board-side model of the signal pair at the device pads.
`timescale 1ns/10ps
module bpg_pad_board (
    input wire i_brd,
    input wire i_p_o,
    input wire i_p_oe,
    input wire i_n_o,
    input wire i_n_oe,
    output logic o_pad_p,
    output logic o_pad_n
);
    // The board releases each line while the device drives it, else drives its half of a complementary pair.
    always_comb
    begin
        o_pad_p = i_p_oe ? i_p_o : i_brd;
        o_pad_n = i_n_oe ? i_n_o : !i_brd;
    end
endmodule

// >>> dv/bpg_pad_ctrl_chk.sv
// Concurrent checks on the ports of the pad gating block.
`timescale 1ns/10ps
module bpg_pad_ctrl_chk (
    input wire I_CLOCK,
    input wire I_RST_N,
    input wire I_PSEL,
    input wire I_PENABLE,
    input wire I_PWRITE,
    input wire [7:0] I_PADDR,
    input wire [31:0] I_PWDATA,
    input wire O_PREADY,
    input wire O_PSLVERR,
    input wire I_PAD_P_I,
    input wire O_PAD_P_O,
    input wire O_PAD_P_OE,
    input wire O_PAD_N_O,
    input wire I_REF_CELL_PRESENT,
    input wire O_RECEIVED,
    input wire O_RECEIVED_INVERTED,
    input wire O_RX_EN,
    input wire O_CAL_TERM_EN,
    input wire O_UNCAL_TERM_EN,
    input wire O_VREF_SCAN_EN
);
    default clocking @(posedge I_CLOCK); endclocking
    default disable iff (!I_RST_N);
    sequence s_ctrl_wr;
        I_PSEL && I_PENABLE && I_PWRITE && I_PADDR == 8'h00;
    endsequence
    sequence s_driving;
        O_PAD_P_OE [*2];
    endsequence
    AST_WR_OE: assert property (s_ctrl_wr |=> O_PAD_P_OE == !$past(I_PWDATA[5]))
        else $error("pad enable does not follow the written tristate bit");
    AST_DRV_TERM: assert property (s_driving |-> !O_CAL_TERM_EN && !O_UNCAL_TERM_EN)
        else $error("termination on while driving");
    AST_OFF_LOW: assert property (!O_RX_EN [*2] |-> !O_RECEIVED)
        else $error("received value not low with receiver off");
    AST_INV_EXCL: assert property (!(O_RECEIVED && O_RECEIVED_INVERTED))
        else $error("true and inverted received values both high");
    AST_RX_SRC: assert property (O_RECEIVED |-> $past(I_PAD_P_I, 3))
        else $error("received high without a high pad three cycles before");
    AST_VREF: assert property (O_VREF_SCAN_EN |-> $past(I_REF_CELL_PRESENT, 3))
        else $error("reference scan without reference cell");
    AST_NPOL: assert property (O_PAD_N_O != O_PAD_P_O)
        else $error("pair drive values not complementary");
    AST_ACCESS: assert property (I_PSEL && !I_PENABLE |=> O_PREADY &&
        (O_PSLVERR == (I_PADDR != 8'h00 && I_PADDR != 8'h04 && I_PADDR != 8'h08)))
        else $error("access phase not answered at once");
endmodule
bind bpg_pad_ctrl bpg_pad_ctrl_chk u_chk (.I_CLOCK(I_CLOCK), .I_RST_N(I_RST_N), .I_PSEL(I_PSEL),
    .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA),
    .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR), .I_PAD_P_I(I_PAD_P_I), .O_PAD_P_O(O_PAD_P_O),
    .O_PAD_P_OE(O_PAD_P_OE), .O_PAD_N_O(O_PAD_N_O), .I_REF_CELL_PRESENT(I_REF_CELL_PRESENT),
    .O_RECEIVED(O_RECEIVED), .O_RECEIVED_INVERTED(O_RECEIVED_INVERTED), .O_RX_EN(O_RX_EN),
    .O_CAL_TERM_EN(O_CAL_TERM_EN), .O_UNCAL_TERM_EN(O_UNCAL_TERM_EN), .O_VREF_SCAN_EN(O_VREF_SCAN_EN));

// >>> dv/bpg_pad_ctrl_tb.sv
// Self-checking bench for the pad gating block.
`timescale 1ns/10ps
module bpg_pad_ctrl_tb;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic brd = 1'b1;
    logic ref_ok = 1'b0;
    logic [31:0] rd;
    logic err;
    wire [31:0] prdata;
    wire [3:0] trim_code;
    wire pready, pslverr, p_i, p_o, p_oe, n_i, n_o, n_oe, rcv, rcv_n, rx_en, cal, uncal, trim_en, vref;
    int n_mismatch = 0;
    int compares = 0;
    // Rows: control word, then expected {receiver, cal term, uncal term, received} with the board high.
    logic [9:0] ctl [15] = '{10'h1F8, 10'h018, 10'h079, 10'h0F9, 10'h179, 10'h019, 10'h27A, 10'h1FA,
        10'h01B, 10'h0FD, 10'h1FE, 10'h1FF, 10'h01F, 10'h011, 10'h014};
    logic [3:0] exp4 [15] = '{4'hF, 4'h9, 4'hF, 4'h6, 4'h9, 4'h0, 4'hD, 4'h6, 4'h0, 4'h6, 4'hF, 4'h9, 4'h0,
        4'h9, 4'h9};

    always #2 clk = ~clk;

    bpg_pad_ctrl dut (.I_CLOCK(clk), .I_RST_N(rst_n), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr),
        .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
        .I_PAD_P_I(p_i), .O_PAD_P_O(p_o), .O_PAD_P_OE(p_oe), .I_PAD_N_I(n_i), .O_PAD_N_O(n_o),
        .O_PAD_N_OE(n_oe), .I_REF_CELL_PRESENT(ref_ok), .O_RECEIVED(rcv), .O_RECEIVED_INVERTED(rcv_n),
        .O_RX_EN(rx_en), .O_CAL_TERM_EN(cal), .O_UNCAL_TERM_EN(uncal), .O_OFFSET_TRIM_ENABLE(trim_en),
        .O_OFFSET_TRIM_CODE(trim_code), .O_VREF_SCAN_EN(vref));

    bpg_pad_board u_board (.i_brd(brd), .i_p_o(p_o), .i_p_oe(p_oe), .i_n_o(n_o), .i_n_oe(n_oe),
        .o_pad_p(p_i), .o_pad_n(n_i));

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Waits on the ready sampled with select and enable; only the watchdog ends a stuck wait.
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1)
            @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask

    task tally_and_finish;
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial
    begin
        #20000;
        n_mismatch++;
        tally_and_finish();
    end

    initial
    begin
        repeat (2) @(posedge clk);
        chk({p_oe, rx_en, cal, uncal}, 4'h7);
        @(posedge clk);
        rst_n <= 1'b1;
        apb(1'b0, 8'h00, 32'h0);
        chk(rd, 32'h68);
        apb(1'b0, 8'h04, 32'h0);
        chk(rd, 32'h0);
        // Both tristate bits always move together.
        for (int i = 0; i < 15; i++)
        begin
            apb(1'b1, 8'h00, {22'h0, ctl[i]});
            repeat (4) @(posedge clk);
            chk(p_oe, !ctl[i][5]);
            chk({rx_en, cal, uncal, rcv}, exp4[i]);
            chk(rcv_n, 1'b0);
            chk({p_o, n_o, n_oe}, {ctl[i][4], !ctl[i][4], ctl[i][2] & !ctl[i][6]});
        end
        apb(1'b1, 8'h0C, 32'hFFFFFFFF);
        chk(err, 1'b1);
        chk(pready, 1'b1);
        apb(1'b1, 8'h08, 32'h3FF);
        chk(err, 1'b0);
        apb(1'b0, 8'h00, 32'h0);
        chk(rd, 32'h014);
        apb(1'b1, 8'h00, 32'h07E);
        brd <= 1'b0;
        repeat (4) @(posedge clk);
        chk({rcv, rcv_n}, 2'h1);
        brd <= 1'b1;
        repeat (3) @(posedge clk);
        chk(rcv, 1'b0);
        @(posedge clk);
        chk(rcv, 1'b1);
        ref_ok <= 1'b1;
        apb(1'b1, 8'h00, 32'h07B);
        apb(1'b1, 8'h04, 32'h1A1);
        repeat (4) @(posedge clk);
        chk({trim_en, trim_code, vref}, 6'h35);
        apb(1'b0, 8'h04, 32'h0);
        chk(rd, 32'h1A1);
        ref_ok <= 1'b0;
        repeat (4) @(posedge clk);
        chk(vref, 1'b0);
        apb(1'b1, 8'h00, 32'h078);
        repeat (4) @(posedge clk);
        chk({trim_en, trim_code}, 5'h0);
        apb(1'b0, 8'h08, 32'h0);
        chk(rd, 32'h0F);
        // A second reset in mid-run must bring back the reset state and the reset control word.
        rst_n <= 1'b0;
        @(posedge clk);
        chk({p_oe, rx_en, cal, uncal, rcv}, 5'h0E);
        rst_n <= 1'b1;
        apb(1'b0, 8'h00, 32'h0);
        chk(rd, 32'h68);
        repeat (4) @(posedge clk);
        chk(rcv, 1'b1);
        tally_and_finish();
    end
endmodule
